// ==== rtl/rssx_pkg.sv ====
// constants for the rotate, subtract and sleep execution block
package rssx_pkg;
    // ahb-lite register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPER = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_FILE = 8'h10;
    localparam logic [7:0] OFS_WDOG = 8'h14;
    // operation codes in ctrl[2:0]; a write of a code starts the operation unless the block is asleep
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_RLC = 3'h1;
    localparam logic [2:0] OP_RRC = 3'h2;
    localparam logic [2:0] OP_SUBL = 3'h3;
    localparam logic [2:0] OP_SLEEP = 3'h4;
    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_SLEEP = 5;
    // reset values
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [4:0] RST_STAT = 5'h18;
    localparam logic [15:0] RST_WDOG = 16'h0000;
    localparam logic [7:0] RST_PRESC = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage : rssx_pkg

// ==== rtl/rssx_exec.sv ====
// execution logic for rotate through carry, subtract from literal and sleep
//
// How it works
// - Rotate left shifts the file operand up one bit, old carry into bit 0, old bit 7 to carry.
// - Rotate left writes the accumulator when destination is 0, else the file register.
// - Rotate right shifts the operand down one bit, old carry into bit 7, old bit 0 to carry.
// - Rotate right writes the accumulator when destination is 0, else the file register.
// - Sleep clears the powerdown flag.
// - Sleep sets the expiry status bit.
// - Sleep clears the watchdog counter and its prescaler.
// - After sleep the core stops executing and the oscillator is halted.
// - Subtract from literal puts literal minus accumulator, mod 256, into the accumulator.
// - Rotate left completes in one instruction cycle as a single word.
`timescale 1ns/100ps
`default_nettype none
module rssx_exec #(
    parameter int WDOG_W = 16,
    parameter int PRESC_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // file register write port
    output logic file_we,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    // power state and accumulator copy
    output logic osc_stop,
    output logic [7:0] acc_out
);

    ////////////////////////////////////////////////////////////////
    // address phase capture

    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic acc_ph;

    assign acc_ph = hsel && hready && htrans[1];

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= acc_ph && hwrite;
            if (acc_ph)
                addr_reg <= haddr;
        end
    end

    // write strobe for one register offset
    function automatic logic wr_hit(input logic pend, input logic [7:0] addr,
        input logic [7:0] ofs);
        return pend && addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////
    // operand holding registers

    logic [7:0] operand_reg;
    logic [7:0] file_in_reg;
    logic [6:0] faddr_reg;
    logic dest_reg;
    logic start_reg;
    logic [2:0] op_reg;
    logic sleeping_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            operand_reg <= 8'h00;
            file_in_reg <= 8'h00;
            faddr_reg <= 7'h00;
            dest_reg <= 1'b0;
        end
        else if (wr_hit(wr_pend_reg, addr_reg, rssx_pkg::OFS_OPER))
        begin
            operand_reg <= hwdata[7:0];
            faddr_reg <= hwdata[14:8];
            dest_reg <= hwdata[15];
        end
        else if (wr_hit(wr_pend_reg, addr_reg, rssx_pkg::OFS_FILE))
            file_in_reg <= hwdata[7:0];
    end

    // a start while asleep is ignored
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            start_reg <= 1'b0;
            op_reg <= rssx_pkg::OP_NONE;
        end
        else
        begin
            start_reg <= wr_hit(wr_pend_reg, addr_reg, rssx_pkg::OFS_CTRL) && !sleeping_reg;
            if (wr_hit(wr_pend_reg, addr_reg, rssx_pkg::OFS_CTRL) && !sleeping_reg)
                op_reg <= hwdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // datapath

    logic [7:0] acc_reg;
    logic c_reg, dc_reg, z_reg, pd_reg, to_reg;
    logic [7:0] rot_res;
    logic rot_c;
    logic [8:0] diff;
    logic [4:0] ndiff;

    always_comb
    begin
        if (op_reg == rssx_pkg::OP_RLC)
        begin
            rot_res = {file_in_reg[6:0], c_reg};
            rot_c = file_in_reg[7];
        end
        else
        begin
            rot_res = {c_reg, file_in_reg[7:1]};
            rot_c = file_in_reg[0];
        end
    end

    assign diff = {1'b0, operand_reg} - {1'b0, acc_reg};
    assign ndiff = {1'b0, operand_reg[3:0]} - {1'b0, acc_reg[3:0]};

    logic is_rot, is_sub, is_sleep;
    assign is_rot = start_reg && (op_reg == rssx_pkg::OP_RLC || op_reg == rssx_pkg::OP_RRC);
    assign is_sub = start_reg && op_reg == rssx_pkg::OP_SUBL;
    assign is_sleep = start_reg && op_reg == rssx_pkg::OP_SLEEP;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            acc_reg <= rssx_pkg::RST_ACC;
        else if (is_rot && !dest_reg)
            acc_reg <= rot_res;
        else if (is_sub)
            acc_reg <= diff[7:0];
        else if (wr_hit(wr_pend_reg, addr_reg, rssx_pkg::OFS_ACC) && !sleeping_reg)
            acc_reg <= hwdata[7:0];
    end

    // destination 1 writes back the file register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            file_we <= 1'b0;
            file_addr <= 7'h00;
            file_wdata <= 8'h00;
        end
        else
        begin
            file_we <= is_rot && dest_reg;
            if (is_rot && dest_reg)
            begin
                file_addr <= faddr_reg;
                file_wdata <= rot_res;
            end
        end
    end

    // status flags, only the ones each op owns
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            {to_reg, pd_reg, z_reg, dc_reg, c_reg} <= rssx_pkg::RST_STAT;
        else if (is_rot)
            c_reg <= rot_c;
        else if (is_sub)
        begin
            c_reg <= ~diff[8];
            dc_reg <= ~ndiff[4];
            z_reg <= diff[7:0] == 8'h00;
        end
        else if (is_sleep)
        begin
            pd_reg <= 1'b0;
            to_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // watchdog and sleep state

    logic [WDOG_W-1:0] wdog_reg;
    logic [PRESC_W-1:0] presc_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wdog_reg <= WDOG_W'(rssx_pkg::RST_WDOG);
            presc_reg <= PRESC_W'(rssx_pkg::RST_PRESC);
        end
        else if (is_sleep)
        begin
            wdog_reg <= '0;
            presc_reg <= '0;
        end
        // counting stands still with the oscillator
        else if (!sleeping_reg)
        begin
            presc_reg <= presc_reg + PRESC_W'(1);
            if (presc_reg == '1)
                wdog_reg <= wdog_reg + WDOG_W'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sleeping_reg <= 1'b0;
            osc_stop <= 1'b0;
        end
        else if (is_sleep)
        begin
            sleeping_reg <= 1'b1;
            osc_stop <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus read data and response

    // zero wait states, every response okay
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // registered accumulator copy for the pins
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            acc_out <= rssx_pkg::RST_ACC;
        else
            acc_out <= acc_reg;
    end

    // read data launched at the address phase edge
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            hrdata <= rssx_pkg::RD_ZERO;
        end
        else
        begin
            if (acc_ph && !hwrite)
            begin
                case (haddr)
                    rssx_pkg::OFS_CTRL: hrdata <= {29'h0, op_reg};
                    rssx_pkg::OFS_OPER: hrdata <= {16'h0, dest_reg, faddr_reg, operand_reg};
                    rssx_pkg::OFS_ACC: hrdata <= {24'h0, acc_reg};
                    rssx_pkg::OFS_STAT: hrdata <= {26'h0, sleeping_reg, to_reg, pd_reg,
                        z_reg, dc_reg, c_reg};
                    rssx_pkg::OFS_FILE: hrdata <= {24'h0, file_in_reg};
                    rssx_pkg::OFS_WDOG: hrdata <= {{(32 - WDOG_W){1'b0}}, wdog_reg};
                    default: hrdata <= rssx_pkg::RD_ZERO;
                endcase
            end
        end
    end

endmodule // rssx_exec
`default_nettype wire

// ==== tb/rssx_exec_properties.sv ====
// port assertions for the rotate, subtract and sleep block
`timescale 1ns/100ps
`default_nettype none
module rssx_exec_properties (
    // clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    // outputs
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic file_we,
    input wire logic osc_stop,
    input wire logic [7:0] acc_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence ctrl_wr(logic [2:0] op);
        hsel && hready && htrans[1] && hwrite && haddr == 8'h00 ##1 hwdata[2:0] == op;
    endsequence
    ready_always_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    osc_hold_a: assert property (osc_stop |=> osc_stop) else $error("osc restarted");
    asleep_no_write_a: assert property (osc_stop |-> !file_we) else $error("write asleep");
    acc_hold_a: assert property (osc_stop && $past(osc_stop) |-> $stable(acc_out))
        else $error("acc moved asleep");
    sub_no_file_a: assert property (ctrl_wr(3'h3) |=> ##1 !file_we)
        else $error("subtract wrote file");
    sleep_stop_a: assert property (ctrl_wr(3'h4) |=> ##1 osc_stop)
        else $error("sleep left osc running");
    reset_quiet_a: assert property ($past(rst) |-> !osc_stop && !file_we && acc_out == 8'h00)
        else $error("outputs not reset");
endmodule // rssx_exec_properties
bind rssx_exec rssx_exec_properties rssx_exec_properties_i (.ref_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .file_we, .osc_stop,
    .acc_out);
`default_nettype wire

// ==== tb/rotate_subtract_sleep_exec_tb.sv ====
// self-checking bench for the rotate, subtract and sleep block
`timescale 1ns/100ps
`default_nettype none
module rotate_subtract_sleep_exec_tb;
    logic ref_clk, rst, hwrite, hreadyout, hresp, file_we, osc_stop, c, dc, z, dst;
    logic [7:0] haddr, acc_out, file_wdata, acc, lit, opnd;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [6:0] file_addr, fa;
    logic [2:0] op;
    logic [8:0] res;
    logic [14:0] fq[$];
    int fails, samples_checked, cyc, seed;
    rssx_exec rssx_exec_i (.ref_clk, .rst, .hsel(1'h1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .file_we,
        .file_addr, .file_wdata, .osc_stop, .acc_out);
    initial
    begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (file_we === 1'h1) fq.push_back({file_addr, file_wdata});
        if (cyc == 5000)
        begin
            fails++;
            stop_test;
        end
    end
    ////////////////////////////////////////
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'h1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'h1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] st(input logic sl, input logic to, input logic pd);
        return {26'h0, sl, to, pd, z, dc, c};
    endfunction
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        seed = 32'hF6E5;
        {rst, htrans, hwrite, haddr, hwdata} <= {1'h1, 43'h0};
        {c, dc, z, acc} = 11'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        xfer(1'h0, rssx_pkg::OFS_STAT, 32'h0);
        chk(rd, st(1'h0, 1'h1, 1'h1));
        xfer(1'h0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        repeat (40)
        begin
            op = 3'(1 + {$random(seed)} % 3);
            {dst, fa, lit, opnd} = 24'($random(seed));
            if (op == rssx_pkg::OP_SUBL)
            begin
                acc = opnd;
                xfer(1'h1, rssx_pkg::OFS_ACC, {24'h0, acc});
            end
            xfer(1'h1, rssx_pkg::OFS_OPER, {16'h0, dst, fa, lit});
            xfer(1'h1, rssx_pkg::OFS_FILE, {24'h0, opnd});
            xfer(1'h1, rssx_pkg::OFS_CTRL, {29'h0, op});
            @(posedge ref_clk);
            case (op)
                rssx_pkg::OP_RLC: res = {opnd, c};
                rssx_pkg::OP_RRC: res = {opnd[0], c, opnd[7:1]};
                default: res = {1'h0, lit} - {1'h0, acc};
            endcase
            c = (op == rssx_pkg::OP_SUBL) ? !res[8] : res[8];
            if (op == rssx_pkg::OP_SUBL)
            begin
                dc = acc[3:0] <= lit[3:0];
                z = res[7:0] == 8'h00;
            end
            if (op == rssx_pkg::OP_SUBL || !dst)
                acc = res[7:0];
            xfer(1'h0, rssx_pkg::OFS_ACC, 32'h0);
            chk(rd, {24'h0, acc});
            chk({24'h0, acc_out}, {24'h0, acc});
            xfer(1'h0, rssx_pkg::OFS_STAT, 32'h0);
            chk(rd, st(1'h0, 1'h1, 1'h1));
            chk(32'(fq.size()), 32'(op != rssx_pkg::OP_SUBL && dst));
            if (fq.size() > 0)
                chk(32'(fq[0]), {17'h0, fa, res[7:0]});
            fq.delete();
        end
        $display("test operations done");
        xfer(1'h1, rssx_pkg::OFS_CTRL, {29'h0, rssx_pkg::OP_SLEEP});
        @(posedge ref_clk);
        xfer(1'h0, rssx_pkg::OFS_WDOG, 32'h0);
        chk(rd, 32'h0);
        xfer(1'h0, rssx_pkg::OFS_STAT, 32'h0);
        chk(rd, st(1'h1, 1'h1, 1'h0));
        chk({31'h0, osc_stop}, 32'h1);
        xfer(1'h1, rssx_pkg::OFS_ACC, 32'h5A);
        xfer(1'h1, rssx_pkg::OFS_OPER, 32'h8000);
        xfer(1'h1, rssx_pkg::OFS_CTRL, 32'h1);
        repeat (2) @(posedge ref_clk);
        xfer(1'h0, rssx_pkg::OFS_ACC, 32'h0);
        chk(rd, {24'h0, acc});
        chk({24'h0, acc_out}, {24'h0, acc});
        chk(32'(fq.size()), 32'h0);
        $display("test sleep done");
        rst <= 1'h1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'h0;
        {c, dc, z, acc} = 11'h0;
        xfer(1'h0, rssx_pkg::OFS_STAT, 32'h0);
        chk(rd, st(1'h0, 1'h1, 1'h1));
        chk({31'h0, osc_stop}, 32'h0);
        $display("test wake done");
        stop_test;
    end
endmodule // rotate_subtract_sleep_exec_tb
`default_nettype wire
